// [design/thas_defs.svh]
// Constants for the tuning, hold and advance supervisor.
// Assumes a 40 MHz pclk; included by the package and the top module.
`ifndef THAS_DEFS_SVH
`define THAS_DEFS_SVH
`define CLK_HZ      40000000
`define TICK_MS     500
`define TICK_CYC    (`CLK_HZ / 1000 * `TICK_MS)
`define SAT_MIN     200
`define SAT_TICKS   (`SAT_MIN * 60 * 1000 / `TICK_MS)
`define ADV_LOCK_S  2
`define LOCK_TICKS  (`ADV_LOCK_S * 1000 / `TICK_MS)
`define PID_SETS    10
`define TICK_W      25
`define SAT_W       15
`define LOCK_W      3
`define OFF_CMD     12'h000
`define OFF_STAT    12'h004
`define CMD_TUNE_ON  0
`define CMD_TUNE_OFF 1
`define CMD_MAN_ON   2
`define CMD_MAN_OFF  3
`define CMD_HOLD_ON  4
`define CMD_HOLD_OFF 5
`define CMD_ADV      6
`endif

// [design/thas_pkg.sv]
// Types shared by the supervisor and its bench.
// Assumes thas_defs.svh is on the include path.
`include "thas_defs.svh"
package thas_pkg;
    typedef enum logic [1:0] {T_OFF, T_STBY, T_EXEC} tune_st_t;

    typedef struct packed {
        logic        running;
        logic        fixed_mode;
        logic        step_flat;
        logic [3:0]  pid_no;
        logic        pv_over;
        logic        zone_by_pv;
        logic        prop_off;
        logic        tune_done;
        logic        out_sat;
        logic        power_fail;
        logic        prog_end;
        logic        soak;
        logic        pv_start_on;
        logic        adv_by_time;
        logic [15:0] adv_time;
        logic [15:0] step_left;
        logic        di_pause_asg;
        logic        di_pause;
        logic        di_man;
    } seq_in_t;

    typedef struct packed {
        logic       tune_lamp;
        logic       tune_exec;
        logic [3:0] tune_pid;
        logic       man_lamp;
        logic       man_active;
        logic       pause_lamp;
        logic       pause_seq;
        logic       defer_params;
        logic       hold_at_pv_start;
        logic       resume_ramp;
        logic       adv_step;
        logic       adv_time;
        logic       soak_cancel;
    } ctl_out_t;

    typedef struct packed {
        tune_st_t               tune;
        logic [`PID_SETS:1]     pid_done;
        logic [`TICK_W-1:0]     tick_cnt;
        logic                   blink;
        logic [`SAT_W-1:0]      sat_cnt;
        logic [`LOCK_W-1:0]     lock_cnt;
        logic                   manual_output;
        logic                   key_pause;
        logic                   run_d;
        logic                   di_man_d;
        ctl_out_t               ctl;
        logic [31:0]            prdata;
        logic                   pready;
        logic                   pslverr;
    } state_t;
endpackage

// [design/tuning_hold_advance_supervisor.sv]
// Mode supervisor: auto tuning, manual output, hold and advance.
// Assumes an APB master on pclk and a program sequencer that reports
// its status synchronously through the seq input struct.
`timescale 1ns/10ps
`default_nettype none
`include "thas_defs.svh"

module tuning_hold_advance_supervisor #(
    parameter logic [`TICK_W-1:0] TICK_CYCLES = `TICK_W'(`TICK_CYC)
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire thas_pkg::seq_in_t seq,
    output thas_pkg::ctl_out_t     ctl
);
    thas_pkg::state_t st_ff;
    thas_pkg::state_t nxt_st;

    logic       wr_acc;
    logic [6:0] cmd;
    logic       pause_now;
    logic       tune_ok;
    logic       tick;
    logic       adv_req;

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    // The slave answers with no wait state: pready rises in the
    // first access cycle, so prdata can come from a flip-flop.
    assign wr_acc = psel & penable & pwrite & st_ff.pready
                    & (paddr == `OFF_CMD);
    assign cmd    = wr_acc ? pwdata[6:0] : 7'h00;

    // ------------------------------------------------------------
    // Derived conditions
    // ------------------------------------------------------------
    assign pause_now = seq.di_pause_asg ? seq.di_pause
                                        : st_ff.key_pause;
    assign tune_ok   = seq.running & ~st_ff.manual_output & ~seq.zone_by_pv
                       & ~seq.pv_over;
    assign tick      = (st_ff.tick_cnt == TICK_CYCLES - 1'b1);
    assign adv_req   = cmd[`CMD_ADV];

    always_comb begin
        nxt_st = st_ff;
        nxt_st.ctl.resume_ramp = 1'b0;
        nxt_st.ctl.adv_step    = 1'b0;
        nxt_st.ctl.adv_time    = 1'b0;
        nxt_st.ctl.soak_cancel = 1'b0;
        nxt_st.run_d    = seq.running;
        nxt_st.di_man_d = seq.di_man;

        // --------------------------------------------------------
        // Time base
        // --------------------------------------------------------
        nxt_st.tick_cnt = tick ? '0 : st_ff.tick_cnt + 1'b1;
        if (tick) begin
            nxt_st.blink = ~st_ff.blink;
        end

        // --------------------------------------------------------
        // Auto tuning
        // --------------------------------------------------------
        if (cmd[`CMD_TUNE_ON] && st_ff.tune == thas_pkg::T_OFF) begin
            if (tune_ok && !(seq.fixed_mode && seq.prop_off)) begin
                nxt_st.tune     = thas_pkg::T_STBY;
                nxt_st.pid_done = '0;
            end
        end
        if (st_ff.tune != thas_pkg::T_OFF) begin
            if (seq.fixed_mode) begin
                nxt_st.tune = thas_pkg::T_EXEC;
                if (seq.tune_done) begin
                    nxt_st.tune = thas_pkg::T_OFF;
                end
            end else begin
                // Sets already tuned stay in standby; unfinished
                // ones keep their done bit clear.
                if (!seq.prop_off && (seq.step_flat || pause_now)
                    && !st_ff.pid_done[seq.pid_no]) begin
                    nxt_st.tune = thas_pkg::T_EXEC;
                end else begin
                    nxt_st.tune = thas_pkg::T_STBY;
                end
                if (st_ff.tune == thas_pkg::T_EXEC
                    && seq.tune_done) begin
                    nxt_st.pid_done[seq.pid_no] = 1'b1;
                    nxt_st.tune = thas_pkg::T_STBY;
                    if (&nxt_st.pid_done) begin
                        nxt_st.tune = thas_pkg::T_OFF;
                    end
                end
                if (seq.prog_end) begin
                    nxt_st.tune = thas_pkg::T_OFF;
                end
            end
        end
        // End conditions sit outside the state test so that they also
        // beat a tune-on request that lands in the same cycle.
        if (!seq.running || seq.power_fail || seq.pv_over || seq.prog_end
            || cmd[`CMD_TUNE_OFF]
            || st_ff.sat_cnt == `SAT_W'(`SAT_TICKS)) begin
            nxt_st.tune = thas_pkg::T_OFF;
        end

        // Saturation time only counts while tuning is on, standby or executing.
        if (st_ff.tune == thas_pkg::T_OFF || !seq.out_sat) begin
            nxt_st.sat_cnt = '0;
        end else if (tick && st_ff.sat_cnt != `SAT_W'(`SAT_TICKS)) begin
            nxt_st.sat_cnt = st_ff.sat_cnt + 1'b1;
        end

        // --------------------------------------------------------
        // Manual output
        // --------------------------------------------------------
        if ((cmd[`CMD_MAN_ON] || (seq.di_man && !st_ff.di_man_d))
            && st_ff.tune == thas_pkg::T_OFF && seq.running) begin
            nxt_st.manual_output = 1'b1;
        end
        if (cmd[`CMD_MAN_OFF] || (!seq.di_man && st_ff.di_man_d)
            || !seq.running) begin
            nxt_st.manual_output = 1'b0;
        end

        // --------------------------------------------------------
        // Hold
        // --------------------------------------------------------
        if (!seq.di_pause_asg) begin
            if (cmd[`CMD_HOLD_ON]) begin
                nxt_st.key_pause = 1'b1;
            end
            if (cmd[`CMD_HOLD_OFF] || !seq.running) begin
                nxt_st.key_pause = 1'b0;
            end
        end
        if (st_ff.ctl.pause_seq && !pause_now) begin
            nxt_st.ctl.resume_ramp = 1'b1;
        end
        if (seq.running && !st_ff.run_d) begin
            nxt_st.ctl.hold_at_pv_start = pause_now
                                          & seq.pv_start_on;
        end

        // --------------------------------------------------------
        // Advance
        // --------------------------------------------------------
        if (st_ff.lock_cnt != '0 && tick) begin
            nxt_st.lock_cnt = st_ff.lock_cnt - 1'b1;
        end
        if (adv_req && seq.running && !seq.fixed_mode && !pause_now
            && st_ff.lock_cnt == '0) begin
            nxt_st.lock_cnt = `LOCK_W'(`LOCK_TICKS);
            if (seq.soak || !seq.adv_by_time
                || seq.adv_time >= seq.step_left) begin
                nxt_st.ctl.adv_step    = 1'b1;
                nxt_st.ctl.soak_cancel = seq.soak;
            end else begin
                nxt_st.ctl.adv_time = 1'b1;
            end
        end

        // --------------------------------------------------------
        // Indicators and control outputs
        // --------------------------------------------------------
        case (nxt_st.tune)
            thas_pkg::T_EXEC: nxt_st.ctl.tune_lamp = nxt_st.blink;
            thas_pkg::T_STBY: nxt_st.ctl.tune_lamp = 1'b1;
            default:          nxt_st.ctl.tune_lamp = 1'b0;
        endcase
        nxt_st.ctl.tune_exec    = (nxt_st.tune == thas_pkg::T_EXEC);
        nxt_st.ctl.tune_pid     = seq.pid_no;
        nxt_st.ctl.man_active   = nxt_st.manual_output;
        nxt_st.ctl.man_lamp     = nxt_st.manual_output & nxt_st.blink;
        nxt_st.ctl.pause_seq    = pause_now & seq.running;
        nxt_st.ctl.pause_lamp   = pause_now & seq.running;
        nxt_st.ctl.defer_params = pause_now & seq.running;

        // --------------------------------------------------------
        // Bus answer
        // --------------------------------------------------------
        nxt_st.pready  = psel & ~penable;
        nxt_st.pslverr = 1'b0;
        if (psel && !penable) begin
            nxt_st.pslverr = (paddr != `OFF_CMD)
                             && (paddr != `OFF_STAT);
            nxt_st.prdata  = '0;
            if (paddr == `OFF_STAT) begin
                nxt_st.prdata = {17'h00000, st_ff.pid_done,
                                 (st_ff.lock_cnt != '0),
                                 st_ff.ctl.pause_seq, st_ff.manual_output,
                                 st_ff.tune};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata  = st_ff.prdata;
    assign pready  = st_ff.pready;
    assign pslverr = st_ff.pslverr;
    assign ctl     = st_ff.ctl;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_tune_on_write;
        cmd[`CMD_TUNE_ON] && st_ff.tune == thas_pkg::T_OFF;
    endsequence
    sequence s_adv_fire;
        ctl.adv_step || ctl.adv_time;
    endsequence
    // One program-mode set finishes its computation this cycle.
    sequence s_prog_set_done;
        st_ff.tune == thas_pkg::T_EXEC && !seq.fixed_mode && seq.tune_done;
    endsequence
    // No end condition is present in this cycle.
    sequence s_no_end;
        seq.running && !seq.power_fail && !seq.pv_over && !seq.prog_end
        && !cmd[`CMD_TUNE_OFF] && st_ff.sat_cnt != `SAT_W'(`SAT_TICKS);
    endsequence

    a_lamp_standby: assert property (
        st_ff.tune == thas_pkg::T_STBY |-> ctl.tune_lamp)
        else $error("Standby lamp not lit.");
    a_lamp_dark: assert property (
        st_ff.tune == thas_pkg::T_OFF |-> !ctl.tune_lamp)
        else $error("Tune lamp lit while off.");
    a_tune_refused: assert property (
        s_tune_on_write ##0 (!seq.running || st_ff.manual_output || seq.pv_over)
        |=> st_ff.tune == thas_pkg::T_OFF)
        else $error("Tuning accepted while forbidden.");
    a_onoff_fixed: assert property (
        s_tune_on_write ##0 (seq.fixed_mode && seq.prop_off)
        |=> st_ff.tune == thas_pkg::T_OFF)
        else $error("On-off fixed tuning not refused.");
    a_power_end: assert property (
        seq.power_fail |=> st_ff.tune == thas_pkg::T_OFF)
        else $error("Tuning survived power loss.");
    a_fixed_done: assert property (
        st_ff.tune != thas_pkg::T_OFF && seq.fixed_mode
        && seq.tune_done |=> st_ff.tune == thas_pkg::T_OFF)
        else $error("Fixed tuning did not end.");
    a_prog_end: assert property (
        seq.prog_end |=> st_ff.tune == thas_pkg::T_OFF && !ctl.tune_lamp)
        else $error("Program end left tuning on.");
    a_manual_refused: assert property (
        cmd[`CMD_MAN_ON] && st_ff.tune != thas_pkg::T_OFF && !st_ff.manual_output
        && !(seq.di_man && !st_ff.di_man_d) |=> !st_ff.manual_output)
        else $error("Manual accepted during tuning.");
    a_adv_in_hold: assert property (
        pause_now && seq.running |=> !(ctl.adv_step || ctl.adv_time))
        else $error("Advance fired during hold.");
    a_adv_lock: assert property (
        s_adv_fire |-> st_ff.lock_cnt != '0
        ##1 (!ctl.adv_step && !ctl.adv_time)[*2])
        else $error("Advance lockout missing.");
    a_soak_step: assert property (
        ctl.soak_cancel |-> ctl.adv_step && !ctl.adv_time)
        else $error("Soak advance not a step.");
    a_reset_end: assert property (
        !seq.running || seq.pv_over |=> st_ff.tune == thas_pkg::T_OFF)
        else $error("Tuning survived reset or overscale.");
    a_sat_end: assert property (
        st_ff.sat_cnt == `SAT_W'(`SAT_TICKS)
        |=> st_ff.tune == thas_pkg::T_OFF)
        else $error("Tuning survived output saturation.");
    a_sets_left: assert property (
        s_prog_set_done ##0 s_no_end
        ##0 ($countones(st_ff.pid_done) < `PID_SETS - 1)
        |=> st_ff.tune == thas_pkg::T_STBY)
        else $error("Program tuning ended with sets left.");
    a_last_set: assert property (
        s_prog_set_done ##0 s_no_end
        ##0 ($countones(st_ff.pid_done) == `PID_SETS - 1)
        ##0 !st_ff.pid_done[seq.pid_no]
        |=> st_ff.tune == thas_pkg::T_OFF)
        else $error("Program tuning kept on after all sets.");
    a_ramp_standby: assert property (
        st_ff.tune != thas_pkg::T_OFF && !seq.fixed_mode
        && !seq.step_flat && !pause_now |=> st_ff.tune != thas_pkg::T_EXEC)
        else $error("Tuning executed on a ramp step.");
    a_hold_exec: assert property (
        st_ff.tune == thas_pkg::T_STBY && !seq.fixed_mode && !seq.prop_off
        && pause_now && !st_ff.pid_done[seq.pid_no] ##0 s_no_end
        |=> st_ff.tune == thas_pkg::T_EXEC)
        else $error("Held program did not execute tuning.");
    a_exec_blink: assert property (
        st_ff.tune == thas_pkg::T_EXEC |-> ctl.tune_lamp == st_ff.blink)
        else $error("Tune lamp not following blink.");
    a_man_lamp: assert property (
        ctl.man_active == st_ff.manual_output && (st_ff.manual_output || !ctl.man_lamp))
        else $error("Manual indicators wrong.");
    a_man_in_reset: assert property (
        !seq.running |=> !st_ff.manual_output)
        else $error("Manual kept in reset state.");
    a_hold_lamp: assert property (
        pause_now && seq.running |=> ctl.pause_lamp && ctl.pause_seq)
        else $error("Hold did not pause the program.");
    a_resume: assert property (
        ctl.pause_seq && !pause_now |=> ctl.resume_ramp)
        else $error("Hold release gave no resume.");
    a_di_priority: assert property (
        seq.di_pause_asg && !seq.di_pause |=> !ctl.pause_seq)
        else $error("Key hold overrode the switch input.");
    a_time_cap: assert property (
        adv_req && seq.adv_by_time && seq.adv_time >= seq.step_left
        |=> !ctl.adv_time)
        else $error("Time advance passed the next step.");
endmodule
`default_nettype wire

// [test/thas_host.sv]
// Host stand-in on the register bus: one APB transfer at a time.
// Assumes the slave answers within 16 access cycles on pclk.
`timescale 1ns/10ps
`default_nettype none
module thas_host (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             hung
);
    // ----------------------------------------------------------------
    // Transfer
    // ----------------------------------------------------------------
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        hung = 1'b0;
    end

    // Address and data are inverted on release so a slave that keeps
    // using them after the transfer reads garbage, not a stale match.
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        q = prdata;
        e = pslverr;
        hung = (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule
`default_nettype wire

// [test/tuning_hold_advance_supervisor_tb_top.sv]
// Self-checking bench for the tuning, hold and advance supervisor.
// Assumes the host model in thas_host.sv; the tick is cut to 4 cycles.
`timescale 1ns/10ps
`default_nettype none
`include "thas_defs.svh"
module tuning_hold_advance_supervisor_tb_top;
    logic               pclk, presetn, psel, penable, pwrite;
    logic [11:0]        paddr;
    logic [31:0]        pwdata, prdata, q;
    logic               pready, pslverr, hung, e, lamp_d;
    thas_pkg::seq_in_t  sq;
    thas_pkg::ctl_out_t ctl;
    int n_fail = 0, checks = 0, n_step = 0, n_atime = 0, n_cancel = 0;
    int n_resume = 0, n_tog = 0, t;

    tuning_hold_advance_supervisor #(.TICK_CYCLES(25'd4))
        i_tuning_hold_advance_supervisor (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .seq(sq), .ctl(ctl));
    thas_host i_thas_host (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .hung(hung));

    // ----------------------------------------------------------------
    // Clock, pulse counters and helpers
    // ----------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        lamp_d <= ctl.tune_lamp;
        if (ctl.tune_lamp !== lamp_d) n_tog++;
        if (ctl.adv_step === 1'b1) n_step++;
        if (ctl.adv_time === 1'b1) n_atime++;
        if (ctl.soak_cancel === 1'b1) n_cancel++;
        if (ctl.resume_ramp === 1'b1) n_resume++;
    end
    task automatic close_out;
        $display("checks %0d errors %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        i_thas_host.xfer(w, a, d, q, e);
        if (hung) begin
            n_fail++;
            close_out();
        end
    endtask
    task automatic cmd(input int b);
        bus(1'b1, `OFF_CMD, 32'h1 << b);
        cyc(2);
    endtask
    task automatic rd;
        cyc(2);
        bus(1'b0, `OFF_STAT, 32'h0);
    endtask
    task automatic tune_is(input logic [31:0] exp);
        rd();
        chk(32'(q[1:0]), exp);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic sc_reset;
        rd();
        chk(q, 32'h0);
        chk(32'(ctl), 32'h0);
        bus(1'b0, 12'h008, 32'h0);
        chk({q[31:1], e}, 32'h1);
    endtask
    task automatic sc_refuse;
        cmd(`CMD_TUNE_ON);
        tune_is(32'h0);
        sq.running <= 1'b1;
        sq.zone_by_pv <= 1'b1;
        cmd(`CMD_TUNE_ON);
        tune_is(32'h0);
        sq.zone_by_pv <= 1'b0;
        sq.pv_over <= 1'b1;
        cmd(`CMD_TUNE_ON);
        tune_is(32'h0);
        sq.pv_over <= 1'b0;
        sq.fixed_mode <= 1'b1;
        sq.prop_off <= 1'b1;
        cmd(`CMD_TUNE_ON);
        tune_is(32'h0);
        sq.fixed_mode <= 1'b0;
        sq.step_flat <= 1'b1;
        sq.pid_no <= 4'h3;
        cmd(`CMD_TUNE_ON);
        tune_is(32'h1);
        cmd(`CMD_TUNE_OFF);
        sq.prop_off <= 1'b0;
        sq.step_flat <= 1'b0;
    endtask
    task automatic sc_prog;
        sq.pid_no <= 4'h2;
        cmd(`CMD_TUNE_ON);
        tune_is(32'h1);
        t = n_tog;
        cyc(12);
        chk({31'h0, ctl.tune_lamp}, 32'(n_tog - t + 1));
        sq.step_flat <= 1'b1;
        tune_is(32'h2);
        chk(32'(ctl.tune_pid), 32'h2);
        chk(32'(ctl.tune_exec), 32'h1);
        t = n_tog;
        cyc(16);
        chk(32'(n_tog - t > 2), 32'h1);
        sq.step_flat <= 1'b0;
        tune_is(32'h1);
        sq.step_flat <= 1'b1;
        tune_is(32'h2);
        sq.tune_done <= 1'b1;
        cyc(1);
        sq.tune_done <= 1'b0;
        tune_is(32'h1);
        chk(32'(q[14:5]), 32'h2);
        cmd(`CMD_HOLD_ON);
        sq.step_flat <= 1'b0;
        sq.pid_no <= 4'h4;
        tune_is(32'h2);
        cmd(`CMD_HOLD_OFF);
        sq.prog_end <= 1'b1;
        cyc(1);
        sq.prog_end <= 1'b0;
        tune_is(32'h0);
        chk(32'(ctl.tune_lamp), 32'h0);
    endtask
    task automatic sc_all_sets;
        sq.step_flat <= 1'b1;
        cmd(`CMD_TUNE_ON);
        for (int i = 1; i <= `PID_SETS; i++) begin
            sq.pid_no <= 4'(i);
            cyc(3);
            sq.tune_done <= 1'b1;
            cyc(1);
            sq.tune_done <= 1'b0;
            cyc(1);
            if (i == `PID_SETS - 1) tune_is(32'h1);
        end
        tune_is(32'h0);
        sq.step_flat <= 1'b0;
    endtask
    task automatic sc_fixed;
        sq.fixed_mode <= 1'b1;
        sq.pid_no <= 4'h1;
        cmd(`CMD_TUNE_ON);
        tune_is(32'h2);
        sq.tune_done <= 1'b1;
        cyc(1);
        sq.tune_done <= 1'b0;
        tune_is(32'h0);
        chk(32'(ctl.tune_lamp), 32'h0);
        cmd(`CMD_TUNE_ON);
        sq.pv_over <= 1'b1;
        tune_is(32'h0);
        sq.pv_over <= 1'b0;
        cmd(`CMD_TUNE_ON);
        sq.power_fail <= 1'b1;
        tune_is(32'h0);
        sq.power_fail <= 1'b0;
        cmd(`CMD_TUNE_ON);
        sq.running <= 1'b0;
        tune_is(32'h0);
        sq.running <= 1'b1;
    endtask
    task automatic sc_manual;
        cmd(`CMD_TUNE_ON);
        cmd(`CMD_MAN_ON);
        rd();
        chk(32'(q[2]), 32'h0);
        cmd(`CMD_TUNE_OFF);
        cmd(`CMD_MAN_ON);
        rd();
        chk(32'(ctl.man_active), 32'h1);
        t = ctl.man_lamp;
        cyc(4);
        chk(32'(ctl.man_lamp != t), 32'h1);
        cmd(`CMD_TUNE_ON);
        tune_is(32'h0);
        cmd(`CMD_MAN_OFF);
        sq.di_man <= 1'b1;
        rd();
        chk(32'(q[2]), 32'h1);
        sq.di_man <= 1'b0;
        sq.running <= 1'b0;
        cyc(2);
        sq.di_man <= 1'b1;
        rd();
        chk(32'(q[2]), 32'h0);
        sq.di_man <= 1'b0;
        sq.running <= 1'b1;
        sq.fixed_mode <= 1'b0;
    endtask
    task automatic sc_adv;
        sq.soak <= 1'b1;
        sq.adv_by_time <= 1'b1;
        sq.adv_time <= 16'd5;
        sq.step_left <= 16'd10;
        cmd(`CMD_ADV);
        chk(32'(n_step + n_cancel * 2 + n_atime * 4), 32'h3);
        cmd(`CMD_ADV);
        chk(32'(n_step), 32'h1);
        cyc(30);
        sq.soak <= 1'b0;
        cmd(`CMD_ADV);
        chk(32'(n_atime), 32'h1);
        cyc(30);
        sq.adv_time <= 16'd20;
        cmd(`CMD_ADV);
        chk(32'(n_step * 4 + n_atime), 32'h9);
        cyc(30);
        sq.soak <= 1'b1;
        cmd(`CMD_HOLD_ON);
        cmd(`CMD_ADV);
        chk(32'(n_step * 4 + n_atime), 32'h9);
        rd();
        chk(32'({q[3], ctl.pause_seq, ctl.pause_lamp}), 32'h7);
    endtask
    task automatic sc_hold;
        sq.running <= 1'b0;
        sq.di_pause_asg <= 1'b1;
        sq.di_pause <= 1'b1;
        sq.pv_start_on <= 1'b1;
        cyc(3);
        sq.running <= 1'b1;
        rd();
        chk(32'(ctl.hold_at_pv_start), 32'h1);
        chk(32'(ctl.defer_params), 32'h1);
        t = n_resume;
        cmd(`CMD_HOLD_OFF);
        rd();
        chk(32'(q[3]), 32'h1);
        sq.di_pause <= 1'b0;
        rd();
        chk(32'(n_resume - t), 32'h1);
        cmd(`CMD_HOLD_ON);
        rd();
        chk(32'(q[3]), 32'h0);
    endtask

    initial begin
        presetn = 1'b0;
        sq = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        sc_reset();
        sc_refuse();
        sc_prog();
        sc_all_sets();
        sc_fixed();
        sc_manual();
        sc_adv();
        sc_hold();
        close_out();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        close_out();
    end
endmodule
`default_nettype wire
